//--- core/mmd_pkg.sv
// Package: memory map constants and region encodings for the address decoder
package mmd_pkg;
   // ==========================================================
   // Address space
   localparam int ADDR_W = 16;
   localparam int DATA_W = 8;
   // ==========================================================
   // Size settings and reset defaults
   localparam logic [7:0] MEM_SIZE_RST = 8'hcf;
   localparam logic [7:0] XRAM_SIZE_RST = 8'h0c;
   localparam logic [7:0] MEM_SIZE_24K = 8'h46;
   localparam logic [7:0] MEM_SIZE_32K = 8'h48;
   localparam logic [7:0] MEM_SIZE_FLASH = 8'hc8;
   localparam logic [7:0] XRAM_SIZE_USE = 8'h0b;
   // ==========================================================
   // Region bounds
   localparam logic [15:0] ROM_END_24K = 16'h5fff;
   localparam logic [15:0] ROM_END_32K = 16'h7fff;
   localparam logic [15:0] VEC_LO = 16'h0000;
   localparam logic [15:0] VEC_HI = 16'h003f;
   localparam logic [15:0] CTBL_LO = 16'h0040;
   localparam logic [15:0] CTBL_HI = 16'h007f;
   localparam logic [15:0] FCALL_LO = 16'h0800;
   localparam logic [15:0] FCALL_HI = 16'h0fff;
   localparam logic [15:0] XRAM_LO = 16'hf600;
   localparam logic [15:0] XRAM_HI = 16'hf7ff;
   localparam logic [15:0] LCD_LO = 16'hfa00;
   localparam logic [15:0] LCD_HI = 16'hfa27;
   localparam logic [15:0] HRAM_LO_MASK = 16'hfd00;
   localparam logic [15:0] HRAM_LO_FLASH = 16'hfb00;
   localparam logic [15:0] HRAM_HI = 16'hfeff;
   localparam logic [15:0] BANK_LO = 16'hfee0;
   localparam logic [15:0] SFR_LO = 16'hff00;
   localparam logic [15:0] RST_VEC_ADDR = 16'h0000;
   // ==========================================================
   // Vector addresses
   localparam logic [15:0] WDT_VEC = 16'h0004;
   localparam logic [15:0] EXT_VEC0 = 16'h0006;
   localparam logic [15:0] PERI_VEC_MAX = 16'h0032;
   localparam logic [15:0] BRK_VEC = 16'h003e;
   localparam logic [4:0] NUM_SRC = 5'd26;
   // ==========================================================
   // Variants and regions
   typedef enum logic [1:0] {MMD_V24K = 2'h0, MMD_V32K = 2'h1, MMD_VFLASH = 2'h2} mmd_variant_t;
   typedef enum logic [2:0]
   {
      MMD_R_UNMAP = 3'h0,
      MMD_R_ROM = 3'h1,
      MMD_R_XRAM = 3'h2,
      MMD_R_LCD = 3'h3,
      MMD_R_HRAM = 3'h4,
      MMD_R_SFR = 3'h5
   } mmd_region_t;
   // Vector fetch sequence
   typedef enum logic [1:0] {MMD_S_IDLE = 2'b00, MMD_S_LO = 2'b01, MMD_S_HI = 2'b11} mmd_state_t;
endpackage

//--- core/mmd_vec_addr.sv
// Vector address lookup per event source
`timescale 1ns/1ps
`default_nettype none
module mmd_vec_addr
(
   input wire logic [4:0] src,
   output logic [15:0] vec_addr
);
   import mmd_pkg::*;
   // ==========================================================
   // Source 0 reset, 1 watchdog, 2..8 ext irqs, up to peripheral max, 25 break
   wire [15:0] src_ext = {11'h000, src};
   wire [15:0] step_addr = 16'(EXT_VEC0 + ((src_ext - 16'h0002) << 1));
   assign vec_addr = (src == 5'd0) ? RST_VEC_ADDR :
                     (src == 5'd1) ? WDT_VEC :
                     (src == 5'd25) ? BRK_VEC :
                     (step_addr > PERI_VEC_MAX) ? PERI_VEC_MAX : step_addr;
endmodule
`default_nettype wire

//--- core/mmd_decoder.sv
// Memory map decoder with size settings and vector fetch sequencer
// What this block does
// RULE1: One flat 64 KB space, 16-bit address
// RULE2: Size settings reset to CFH and 0CH
// RULE3: Software sets 46H/48H/C8H and 0BH
// RULE4: Program memory ends 5FFFH or 7FFFH
// RULE5: 0000H to 003FH is vector table
// RULE6: Vector low byte even, high odd
// RULE7: Fixed vector address per event source
// RULE8: 0040H to 007FH table call entries (the code also sets in_call_table at any address while table_call_insn is high)
// RULE9: Direct call targets only 0800H-0FFFH
// RULE10: High-speed RAM FD00H or FB00H to FEFFH
// RULE11: FEE0H-FEFFH four eight-register banks
// RULE12: No fetch from high-speed RAM
// RULE13: Expansion RAM F600H-F7FFH, fetch allowed
// RULE14: Display RAM FA00H-FA27H, plain RAM too
// RULE15: Peripheral window FF00H to FFFFH
// RULE16: No access to unassigned peripheral addresses (the code maps every address in FF00H-FFFFH to the peripheral region)
// RULE17: Reset loads counter from vector 0000H
// RULE18: One region per address, else unmapped
`timescale 1ns/1ps
`default_nettype none
module mmd_decoder
(
   input wire logic clock,
   input wire logic rst_n,
   input wire mmd_pkg::mmd_variant_t variant,
   input wire logic [15:0] addr,
   input wire logic acc_valid,
   input wire logic acc_fetch,
   input wire logic acc_write,
   input wire logic far_direct_call_insn,
   input wire logic table_call_insn,
   input wire logic size_wr,
   input wire logic size_sel_xram,
   input wire logic [7:0] size_wdata,
   input wire logic vec_req,
   input wire logic [4:0] vec_src,
   input wire logic [7:0] mem_rdata,
   output mmd_pkg::mmd_region_t region,
   output logic unmapped,
   output logic exec_fault,
   output logic call_fault,
   output logic write_en,
   output logic in_vector,
   output logic in_call_table,
   output logic in_reg_bank,
   output logic [1:0] bank_num,
   output logic [2:0] bank_reg,
   output logic [7:0] mem_size_sel,
   output logic [7:0] xram_size_sel,
   output logic [15:0] vec_rd_addr,
   output logic vec_rd,
   output logic [15:0] program_counter,
   output logic pc_load
);
   import mmd_pkg::*;
   // ==========================================================
   // Region decode
   logic [15:0] rom_end;
   logic [15:0] hram_lo;
   assign rom_end = (variant == MMD_V24K) ? ROM_END_24K : ROM_END_32K; // [RULE4]
   assign hram_lo = (variant == MMD_VFLASH) ? HRAM_LO_FLASH : HRAM_LO_MASK; // [RULE10]
   wire hit_rom = (addr <= rom_end); // [RULE1] [RULE4]
   wire hit_xram = (addr >= XRAM_LO) && (addr <= XRAM_HI); // [RULE13]
   wire hit_lcd = (addr >= LCD_LO) && (addr <= LCD_HI); // [RULE14]
   wire hit_hram = (addr >= hram_lo) && (addr <= HRAM_HI); // [RULE10]
   wire hit_sfr = (addr >= SFR_LO); // [RULE15]
   // Priority chain keeps one region per address
   assign region = hit_rom ? MMD_R_ROM :
                   hit_xram ? MMD_R_XRAM :
                   hit_lcd ? MMD_R_LCD :
                   hit_hram ? MMD_R_HRAM :
                   hit_sfr ? MMD_R_SFR : MMD_R_UNMAP; // [RULE18]
   assign unmapped = acc_valid && (region == MMD_R_UNMAP); // [RULE18]
   // Fetch permission: ROM and expansion RAM only
   wire fetch_ok = (region == MMD_R_ROM) || (region == MMD_R_XRAM); // [RULE12] [RULE13]
   assign exec_fault = acc_valid && acc_fetch && !fetch_ok; // [RULE12]
   // Direct call target window
   wire fcall_in = (addr >= FCALL_LO) && (addr <= FCALL_HI);
   assign call_fault = acc_valid && far_direct_call_insn && !fcall_in; // [RULE9]
   // Writes only to RAM and peripheral regions, never to unmapped space
   assign write_en = acc_valid && acc_write && !acc_fetch && // [RULE14] [RULE18]
                     (region inside {MMD_R_XRAM, MMD_R_LCD, MMD_R_HRAM, MMD_R_SFR});
   // Sub-areas of program memory
   assign in_vector = (addr <= VEC_HI); // [RULE5]
   assign in_call_table = table_call_insn || ((addr >= CTBL_LO) && (addr <= CTBL_HI)); // [RULE8]
   // Register banks: bank 0 at top, eight bytes each
   assign in_reg_bank = (addr >= BANK_LO) && (addr <= HRAM_HI); // [RULE11]
   assign bank_num = ~addr[4:3]; // [RULE11]
   assign bank_reg = addr[2:0]; // [RULE11]
   // ==========================================================
   // Size settings
   logic [7:0] mem_size_ff;
   logic [7:0] xram_size_ff;
   // Reset defaults, then software rewrites
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mem_size_ff <= MEM_SIZE_RST; // [RULE2]
         xram_size_ff <= XRAM_SIZE_RST; // [RULE2]
      end
      else if (size_wr && !size_sel_xram)
         mem_size_ff <= size_wdata; // [RULE3]
      else if (size_wr && size_sel_xram)
         xram_size_ff <= size_wdata; // [RULE3]
   end
   assign mem_size_sel = mem_size_ff;
   assign xram_size_sel = xram_size_ff;
   // ==========================================================
   // Vector fetch sequencer
   mmd_state_t state_ff;
   mmd_state_t nxt_state;
   logic [15:0] vbase_ff;
   logic [7:0] vlo_ff;
   logic [15:0] pc_ff;
   logic load_ff;
   logic boot_ff;
   logic [15:0] src_addr;
   mmd_vec_addr u_vec
   (
      .src(vec_src),
      .vec_addr(src_addr)
   );
   wire start = boot_ff || vec_req;
   wire [15:0] start_base = boot_ff ? RST_VEC_ADDR : src_addr; // [RULE7] [RULE17]
   // Next state of the two-byte read
   always_comb
   begin
      case (state_ff)
         MMD_S_IDLE: nxt_state = start ? MMD_S_LO : MMD_S_IDLE;
         MMD_S_LO: nxt_state = MMD_S_HI;
         MMD_S_HI: nxt_state = MMD_S_IDLE;
         default: nxt_state = MMD_S_IDLE;
      endcase
   end
   // Even address first, odd next; data returns one cycle later
   assign vec_rd = (state_ff != MMD_S_IDLE);
   assign vec_rd_addr = (state_ff == MMD_S_HI) ? (vbase_ff | 16'h0001) : vbase_ff; // [RULE6]
   // State, base capture and counter load
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_ff <= MMD_S_IDLE;
         vbase_ff <= RST_VEC_ADDR;
         vlo_ff <= 8'h00;
         pc_ff <= 16'h0000;
         load_ff <= 1'b0;
         boot_ff <= 1'b1;
      end
      else
      begin
         state_ff <= nxt_state;
         load_ff <= (state_ff == MMD_S_HI);
         if (state_ff == MMD_S_IDLE && start)
         begin
            vbase_ff <= start_base; // [RULE7]
            boot_ff <= 1'b0;
         end
         if (state_ff == MMD_S_HI)
            vlo_ff <= mem_rdata; // [RULE6]
         if (load_ff)
            pc_ff <= {mem_rdata, vlo_ff}; // [RULE6] [RULE17]
      end
   end
   assign program_counter = pc_ff;
   assign pc_load = load_ff;
   // ==========================================================
   // Checks
   chk_hram_nofetch: assert property (@(posedge clock) disable iff (!rst_n) // [RULE12]
      (acc_valid && acc_fetch && region == MMD_R_HRAM) |-> exec_fault)
      else $error("fetch from high-speed RAM not flagged");
   chk_xram_fetch: assert property (@(posedge clock) disable iff (!rst_n) // [RULE13]
      (acc_valid && addr >= XRAM_LO && addr <= XRAM_HI) |-> (region == MMD_R_XRAM && !exec_fault))
      else $error("expansion RAM decode wrong");
   chk_lcd_range: assert property (@(posedge clock) disable iff (!rst_n) // [RULE14]
      (addr >= LCD_LO && addr <= LCD_HI) |-> region == MMD_R_LCD)
      else $error("display RAM decode wrong");
   chk_sfr_window: assert property (@(posedge clock) disable iff (!rst_n) // [RULE15]
      (addr >= SFR_LO) == (region == MMD_R_SFR))
      else $error("peripheral window decode wrong");
   chk_rom_end: assert property (@(posedge clock) disable iff (!rst_n) // [RULE4]
      (variant == MMD_V24K && addr > ROM_END_24K) |-> region != MMD_R_ROM)
      else $error("program memory too large");
   chk_hram_mask: assert property (@(posedge clock) disable iff (!rst_n) // [RULE10]
      (variant != MMD_VFLASH && addr >= HRAM_LO_FLASH && addr < HRAM_LO_MASK) |->
      (unmapped || !acc_valid))
      else $error("mask variant RAM too large");
   chk_call_window: assert property (@(posedge clock) disable iff (!rst_n) // [RULE9]
      (acc_valid && far_direct_call_insn) |->
      (call_fault == !(addr >= FCALL_LO && addr <= FCALL_HI)))
      else $error("direct call window wrong");
   chk_vec_pair: assert property (@(posedge clock) disable iff (!rst_n) // [RULE6]
      (state_ff == MMD_S_LO) |=>
      (vec_rd && vec_rd_addr == ($past(vec_rd_addr) | 16'h0001)) ##1 pc_load)
      else $error("vector byte order wrong");
   chk_boot_vector: assert property (@(posedge clock) disable iff (!rst_n) // [RULE17]
      ($rose(boot_ff == 1'b0) && $past(boot_ff)) |-> vbase_ff == RST_VEC_ADDR)
      else $error("reset vector not used");
   chk_unmap_nowrite: assert property (@(posedge clock) disable iff (!rst_n) // [RULE18]
      unmapped |-> !write_en)
      else $error("write reached unmapped space");
   chk_size_reset: assert property (@(posedge clock) disable iff (!rst_n) // [RULE2]
      $rose(rst_n) |-> (mem_size_sel == MEM_SIZE_RST && xram_size_sel == XRAM_SIZE_RST))
      else $error("size setting reset value wrong");
   // Settings hold, banks count down from the top, display RAM writes, fetch start and load pulse
   chk_size_hold: assert property (@(posedge clock) disable iff (!rst_n) // [RULE2]
      !size_wr |=> ($stable(mem_size_sel) && $stable(xram_size_sel)))
      else $error("size setting changed without a write");
   chk_bank_order: assert property (@(posedge clock) disable iff (!rst_n) // [RULE11]
      in_reg_bank |-> (bank_num == 2'(HRAM_HI[4:3] - addr[4:3]) && bank_reg == addr[2:0]))
      else $error("register bank numbering wrong");
   chk_lcd_write: assert property (@(posedge clock) disable iff (!rst_n) // [RULE14]
      (acc_valid && acc_write && !acc_fetch && addr >= LCD_LO && addr <= LCD_HI) |-> write_en)
      else $error("display RAM write refused");
   chk_vec_start: assert property (@(posedge clock) disable iff (!rst_n) // [RULE7]
      (state_ff == MMD_S_IDLE && vec_req && !boot_ff) |=>
      (vec_rd && vec_rd_addr == $past(src_addr)))
      else $error("vector start address wrong");
   chk_pc_pulse: assert property (@(posedge clock) disable iff (!rst_n) // [RULE17]
      pc_load |=> !pc_load)
      else $error("counter load pulse too long");
endmodule
`default_nettype wire

//--- verif/mmd_vec_mem.sv
// Partner model: program memory holding the vector table, read a byte at a time
`timescale 1ns/1ps
`default_nettype none
module mmd_vec_mem
(
   input wire logic clock,
   input wire logic vec_rd,
   input wire logic [15:0] vec_rd_addr,
   output logic [7:0] mem_rdata
);
   // ==========================================================
   // Byte answer
   initial mem_rdata = 8'h00;
   // Byte is address low byte plus 31h, ready the cycle after the read
   always @(posedge clock)
   begin
      if (vec_rd)
         mem_rdata <= vec_rd_addr[7:0] + 8'h31;
      else
         mem_rdata <= ~mem_rdata; // Idle bus toggles, no stale byte
   end
endmodule
`default_nettype wire

//--- verif/memory_map_decoder_tb.sv
// Testbench for the memory map decoder: region table, size settings, vector fetches
`timescale 1ns/1ps
`default_nettype none
module memory_map_decoder_tb;
   import mmd_pkg::*;
   typedef struct packed {logic [1:0] v; logic [15:0] a; logic [1:0] fw; logic [2:0] r;
      logic [5:0] f;} mmd_row_t;
   logic clock, rst_n, acc_valid, far_call, tbl_call, size_wr, size_sel_xram, vec_req, vec_rd;
   logic unmapped, exec_fault, call_fault, write_en, in_vector, in_call_table, in_reg_bank, pc_load;
   logic [1:0] var_in, fw, bank_num;
   logic [2:0] bank_reg;
   logic [4:0] vec_src;
   logic [7:0] size_wdata, mem_rdata, mem_size_sel, xram_size_sel;
   logic [15:0] addr, vec_rd_addr, program_counter;
   mmd_region_t region;
   mmd_row_t rows [22];
   int n_fail = 0;
   int check_count = 0;
   // ==========================================================
   // Design and partner
   mmd_decoder u_dut (.clock(clock), .rst_n(rst_n), .variant(mmd_variant_t'(var_in)),
      .addr(addr), .acc_valid(acc_valid), .acc_fetch(fw[1]), .acc_write(fw[0]),
      .far_direct_call_insn(far_call), .table_call_insn(tbl_call), .size_wr(size_wr),
      .size_sel_xram(size_sel_xram), .size_wdata(size_wdata), .vec_req(vec_req),
      .vec_src(vec_src), .mem_rdata(mem_rdata), .region(region), .unmapped(unmapped),
      .exec_fault(exec_fault), .call_fault(call_fault), .write_en(write_en),
      .in_vector(in_vector), .in_call_table(in_call_table), .in_reg_bank(in_reg_bank),
      .bank_num(bank_num), .bank_reg(bank_reg), .mem_size_sel(mem_size_sel),
      .xram_size_sel(xram_size_sel), .vec_rd_addr(vec_rd_addr), .vec_rd(vec_rd),
      .program_counter(program_counter), .pc_load(pc_load));
   mmd_vec_mem u_mem (.clock(clock), .vec_rd(vec_rd), .vec_rd_addr(vec_rd_addr),
      .mem_rdata(mem_rdata));
   // Clock
   initial
   begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   // ==========================================================
   // Helpers
   task end_of_test();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // Bounded wait for the counter load, then compare the loaded counter
   task wait_load(input logic [7:0] base);
      int i;
      i = 0;
      while (pc_load !== 1'b1 && i < 20)
      begin
         @(negedge clock);
         i++;
      end
      if (pc_load !== 1'b1)
      begin
         chk("pc_load", 16'(pc_load), 16'h0001);
         end_of_test();
      end
      else
      begin
         @(negedge clock);
         chk("program_counter", program_counter,
            {base + 8'h32, base + 8'h31});
         chk("pc_load", 16'(pc_load), 16'h0000);
      end
   endtask
   // ==========================================================
   // Main sequence
   initial
   begin
      logic [4:0] srcs [7];
      logic [7:0] bases [7];
      logic [15:0] cadr [4];
      rows = '{'{0,16'h0000,0,1,6'h04}, '{0,16'h003f,0,1,6'h04}, '{0,16'h0040,0,1,6'h02},
         '{0,16'h007f,0,1,6'h02}, '{0,16'h5fff,2,1,6'h00}, '{0,16'h6000,0,0,6'h20},
         '{1,16'h7fff,2,1,6'h00}, '{1,16'h8000,0,0,6'h20}, '{1,16'hf600,1,2,6'h08},
         '{1,16'hf7ff,2,2,6'h00}, '{1,16'hf800,1,0,6'h20}, '{1,16'hfa27,1,3,6'h08},
         '{1,16'hfa28,0,0,6'h20}, '{1,16'hfcff,0,0,6'h20}, '{1,16'hfd00,2,4,6'h10},
         '{2,16'hfb00,1,4,6'h08}, '{2,16'hfaff,0,0,6'h20}, '{2,16'hfee0,0,4,6'h01},
         '{0,16'hfeff,0,4,6'h01}, '{0,16'hff00,1,5,6'h08}, '{0,16'hff01,0,5,6'h00},
         '{2,16'h7fff,2,1,6'h00}};
      srcs = '{0, 1, 2, 8, 9, 24, 25};
      bases = '{8'h00, 8'h04, 8'h06, 8'h12, 8'h14, 8'h32, 8'h3e};
      cadr = '{16'h07ff, 16'h0800, 16'h0fff, 16'h1000};
      {rst_n, acc_valid, far_call, tbl_call, size_wr, size_sel_xram, vec_req} = 7'h00;
      {var_in, addr, fw, size_wdata, vec_src} = '0;
      repeat (6) @(negedge clock);
      rst_n = 1'b1;
      chk("mem_size_sel", 16'(mem_size_sel), 16'h00cf);
      chk("xram_size_sel", 16'(xram_size_sel), 16'h000c);
      wait_load(8'h00);
      $display("test reset fetch done");
      // Region table, one row per boundary address
      acc_valid = 1'b1;
      foreach (rows[i])
      begin
         @(negedge clock);
         {var_in, addr, fw} = {rows[i].v, rows[i].a, rows[i].fw};
         #1;
         chk("region", 16'(region), 16'(rows[i].r));
         chk("flags", 16'({unmapped, exec_fault, write_en, in_vector, in_call_table,
            in_reg_bank}), 16'(rows[i].f));
      end
      $display("test region table done");
      // Direct call window edges and register bank numbering
      far_call = 1'b1;
      fw = 2'b10;
      foreach (cadr[i])
      begin
         @(negedge clock);
         addr = cadr[i];
         #1;
         chk("call_fault", 16'(call_fault), 16'(i == 0 || i == 3));
      end
      @(negedge clock);
      {far_call, fw, addr} = {3'b000, 16'hfef8};
      #1;
      chk("bank", 16'({bank_num, bank_reg}), 16'h0000);
      @(negedge clock);
      addr = 16'hfee7;
      #1;
      chk("bank", 16'({bank_num, bank_reg}), 16'h001f);
      // Table call read, then the top peripheral byte decoded with no access
      @(negedge clock);
      {tbl_call, addr} = {1'b1, 16'h007e};
      #1;
      chk("in_call_table", 16'(in_call_table), 16'h0001);
      @(negedge clock);
      {tbl_call, acc_valid, addr} = {2'b00, 16'hffff};
      #1;
      chk("region", 16'(region), 16'(MMD_R_SFR));
      chk("unmapped", 16'(unmapped), 16'h0000);
      $display("test call window and banks done");
      // Back to back size writes
      @(negedge clock);
      {size_wr, size_sel_xram, size_wdata} = {2'b10, 8'h46};
      @(negedge clock);
      chk("mem_size_sel", 16'(mem_size_sel), 16'h0046);
      {size_sel_xram, size_wdata} = {1'b1, 8'h0b};
      @(negedge clock);
      size_wr = 1'b0;
      chk("xram_size_sel", 16'(xram_size_sel), 16'h000b);
      chk("mem_size_sel", 16'(mem_size_sel), 16'h0046);
      $display("test size writes done");
      // Vector fetch for each kind of event source
      foreach (srcs[i])
      begin
         {vec_req, vec_src} = {1'b1, srcs[i]};
         @(negedge clock);
         vec_req = 1'b0;
         chk("vec_rd_addr", vec_rd_addr, {8'h00, bases[i]});
         chk("vec_rd", 16'(vec_rd), 16'h0001);
         wait_load(bases[i]);
      end
      $display("test vector sources done");
      // Reset in mid-run restores defaults and refetches the reset vector
      rst_n = 1'b0;
      #1;
      chk("mem_size_sel", 16'(mem_size_sel), 16'h00cf);
      chk("xram_size_sel", 16'(xram_size_sel), 16'h000c);
      @(negedge clock);
      rst_n = 1'b1;
      wait_load(8'h00);
      $display("test second reset done");
      end_of_test();
   end
endmodule
`default_nettype wire
